// ===== bench/cmbe_exec_asserts.sv
`timescale 1ns/1ps
`include "cmbe_consts.vh"
module cmbe_exec_asserts (
  // clock and reset
  input wire                   i_clk,
  input wire                   i_nrst,
  // request
  input wire                   i_valid,
  input wire [`CMBE_OP_W-1:0]  i_op,
  // results
  input wire                   o_ready,
  input wire                   o_done,
  input wire                   o_pc_we,
  input wire [15:0]            o_product,
  input wire                   o_product_we,
  input wire [7:0]             o_status,
  input wire                   o_status_we,
  input wire                   o_push_we,
  input wire [`CMBE_CYC_W-1:0] o_cycles
);
  reg  [3:0] cnt_r;
  wire       acc = i_valid && o_ready;
  wire       mul = i_op <= `CMBE_OP_FSUMUL;
  wire       jump = i_op >= `CMBE_OP_REL_JUMP && i_op <= `CMBE_OP_EPTR_JUMP;
  wire       cal = i_op >= `CMBE_OP_REL_CALL && i_op <= `CMBE_OP_EPTR_CALL;
  wire       cmp = i_op >= `CMBE_OP_CMP && i_op <= `CMBE_OP_CMP_CONST;
  // cycles since the last accept, saturating
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) cnt_r <= 4'h0;
    else if (acc) cnt_r <= 4'h1;
    else if (cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  chk_mul_timing: assert property (
    acc && mul |=> !o_done && !o_ready ##1 o_done && o_product_we && o_status_we) else $error("multiply timing");
  chk_jump_timing: assert property (
    acc && jump |=> !o_done ##1 o_done && o_pc_we && !o_status_we) else $error("jump timing");
  chk_call_timing: assert property (
    acc && cal |=> (!o_done) [*2] ##1 o_done && o_push_we && o_pc_we) else $error("call timing");
  chk_cmp_timing: assert property (
    acc && cmp |=> o_done && o_status_we && !o_pc_we && o_cycles == `CMBE_CYC_CMP) else $error("compare timing");
  chk_cycle_count: assert property (
    o_done |-> !cnt_r[3] && o_cycles == cnt_r[2:0]) else $error("cycle count mismatch");
  chk_flags_kept: assert property (
    o_pc_we |-> !o_status_we && !o_product_we) else $error("flags written by branch");
  chk_zero_flag: assert property (
    o_product_we |-> o_status[`CMBE_F_Z] == (o_product == 16'h0000)) else $error("zero flag wrong");
  chk_strobe_done: assert property (
    (o_pc_we || o_product_we || o_status_we || o_push_we) |-> o_done && o_ready) else $error("stray strobe");
  cov_mul: cover property (acc && mul);
  cov_call: cover property (acc && cal);
  cov_b2b: cover property (acc && cmp ##1 acc);
endmodule // cmbe_exec_asserts

bind cmbe_exec cmbe_exec_asserts u_chk (.i_clk, .i_nrst, .i_valid, .i_op, .o_ready, .o_done, .o_pc_we,
  .o_product, .o_product_we, .o_status, .o_status_we, .o_push_we, .o_cycles);

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`include "cmbe_consts.vh"
module tb_top;
  typedef struct {
    logic [5:0]  op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  st;
    logic [3:0]  x;
    logic [21:0] pc;
    logic [2:0]  cyc;
    logic [15:0] res;
  } cmbe_row_t;
  logic        i_clk, i_nrst, i_valid, i_next_two_word;
  logic [5:0]  i_op;
  logic [7:0]  i_rd_val, i_rr_val, i_const, i_io_val, i_status;
  logic [2:0]  i_bit_sel;
  wire  [11:0] i_offset     = 12'hFF0;
  wire  [21:0] i_abs_target = 22'h3ABCDE;
  wire  [21:0] i_pc         = 22'h000100;
  wire  [15:0] i_z_ptr      = 16'h1234;
  wire  [5:0]  i_ext_addr   = 6'h2A;
  wire         o_ready, o_done, o_pc_we, o_product_we, o_status_we, o_push_we;
  wire  [21:0] o_pc_next, o_ret_addr;
  wire  [15:0] o_product;
  wire  [7:0]  o_status;
  wire  [2:0]  o_cycles;
  integer      fails, compares, n;
  // op, rd/io, rr/const, status, {two-word, bit} or multiply {Z, C}, pc, cycles, product or status
  cmbe_row_t rows[$] = '{
    '{`CMBE_OP_UMUL,8'hFF,8'hFF,8'h00,4'h1,22'h000101,3'h2,16'hFE01},
    '{`CMBE_OP_UMUL,8'h00,8'hFF,8'h00,4'h2,22'h000101,3'h2,16'h0000},
    '{`CMBE_OP_SMUL,8'hFF,8'hFF,8'h00,4'h0,22'h000101,3'h2,16'h0001},
    '{`CMBE_OP_SUMUL,8'hFF,8'h02,8'h00,4'h1,22'h000101,3'h2,16'hFFFE},
    '{`CMBE_OP_FUMUL,8'hFF,8'hFF,8'h00,4'h1,22'h000101,3'h2,16'hFC02},
    '{`CMBE_OP_FSMUL,8'h80,8'h80,8'h00,4'h0,22'h000101,3'h2,16'h8000},
    '{`CMBE_OP_FSUMUL,8'h40,8'h80,8'h00,4'h0,22'h000101,3'h2,16'h4000},
    '{`CMBE_OP_REL_JUMP,8'h00,8'h00,8'h00,4'h0,22'h0000F1,3'h2,16'h0000},
    '{`CMBE_OP_PTR_JUMP,8'h00,8'h00,8'h00,4'h0,22'h001234,3'h2,16'h0000},
    '{`CMBE_OP_EPTR_JUMP,8'h00,8'h00,8'h00,4'h0,22'h2A1234,3'h2,16'h0000},
    '{`CMBE_OP_ABS_JUMP,8'h00,8'h00,8'h00,4'h0,22'h3ABCDE,3'h3,16'h0000},
    '{`CMBE_OP_REL_CALL,8'h00,8'h00,8'h00,4'h0,22'h0000F1,3'h3,16'h0000},
    '{`CMBE_OP_PTR_CALL,8'h00,8'h00,8'h00,4'h0,22'h001234,3'h3,16'h0000},
    '{`CMBE_OP_EPTR_CALL,8'h00,8'h00,8'h00,4'h0,22'h2A1234,3'h3,16'h0000},
    '{`CMBE_OP_SKIP_EQ,8'h05,8'h05,8'h00,4'h0,22'h000102,3'h2,16'h0000},
    '{`CMBE_OP_SKIP_EQ,8'h05,8'h06,8'h00,4'h8,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_SKIP_RB_CLR,8'h00,8'hF7,8'h00,4'hB,22'h000103,3'h3,16'h0000},
    '{`CMBE_OP_SKIP_RB_SET,8'h00,8'hF7,8'h00,4'h3,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_SKIP_IO_CLR,8'h08,8'h00,8'h00,4'h3,22'h000101,3'h2,16'h0000},
    '{`CMBE_OP_SKIP_IO_SET,8'h08,8'h00,8'h00,4'hB,22'h000103,3'h4,16'h0000},
    '{`CMBE_OP_CMP,8'h05,8'h05,8'h80,4'h0,22'h000101,3'h1,16'h0082},
    '{`CMBE_OP_CMP,8'h00,8'h01,8'h80,4'h0,22'h000101,3'h1,16'h00B5},
    '{`CMBE_OP_CMP_BORROW,8'h05,8'h05,8'h03,4'h0,22'h000101,3'h1,16'h0035},
    '{`CMBE_OP_CMP_BORROW,8'h05,8'h05,8'h00,4'h0,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_CMP_CONST,8'h80,8'h01,8'h00,4'h0,22'h000101,3'h1,16'h0038},
    '{`CMBE_OP_BR_FLAG_SET,8'h00,8'h00,8'h02,4'h1,22'h0000F1,3'h2,16'h0000},
    '{`CMBE_OP_BR_FLAG_CLR,8'h00,8'h00,8'h02,4'h1,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_BR_SGE,8'h00,8'h00,8'h0C,4'h0,22'h0000F1,3'h2,16'h0000},
    '{`CMBE_OP_BR_SLT,8'h00,8'h00,8'h0C,4'h0,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_BR_USH,8'h00,8'h00,8'h01,4'h0,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_BR_ULO,8'h00,8'h00,8'h01,4'h0,22'h0000F1,3'h2,16'h0000},
    '{`CMBE_OP_BR_HSET,8'h00,8'h00,8'h20,4'h0,22'h0000F1,3'h2,16'h0000},
    '{`CMBE_OP_BR_HCLR,8'h00,8'h00,8'h20,4'h0,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_BR_TSET,8'h00,8'h00,8'h40,4'h0,22'h0000F1,3'h2,16'h0000},
    '{`CMBE_OP_BR_TCLR,8'h00,8'h00,8'h40,4'h0,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_BR_VSET,8'h00,8'h00,8'h00,4'h0,22'h000101,3'h1,16'h0000},
    '{`CMBE_OP_BR_VCLR,8'h00,8'h00,8'h00,4'h0,22'h0000F1,3'h2,16'h0000},
    '{`CMBE_OP_BR_IEN,8'h00,8'h00,8'h80,4'h0,22'h0000F1,3'h2,16'h0000},
    '{`CMBE_OP_BR_IDIS,8'h00,8'h00,8'h80,4'h0,22'h000101,3'h1,16'h0000},
    '{6'h3F,8'h00,8'h00,8'h00,4'h0,22'h000101,3'h1,16'h0000}};

  cmbe_exec dut (.i_clk, .i_nrst, .i_valid, .i_op, .i_rd_val, .i_rr_val, .i_const, .i_bit_sel, .i_io_val,
    .i_offset, .i_abs_target, .i_next_two_word, .i_pc, .i_z_ptr, .i_ext_addr, .i_status, .o_ready, .o_done,
    .o_pc_next, .o_pc_we, .o_product, .o_product_we, .o_status, .o_status_we, .o_ret_addr, .o_push_we, .o_cycles);

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic close_out;
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // issue one operation and wait for its done pulse
  task automatic go(input cmbe_row_t r);
    @(posedge i_clk);
    i_valid <= 1'b1;
    {i_op, i_rd_val, i_io_val, i_rr_val, i_const, i_status} <= {r.op, r.a, r.a, r.b, r.b, r.st};
    {i_next_two_word, i_bit_sel} <= r.x;
    @(posedge i_clk);
    i_valid <= 1'b0;
    n = 1;
    #1;
    while (o_done !== 1'b1 && n < 6) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(n[23:0], {21'h0, r.cyc}, "measured cycles");
    chk({21'h0, o_cycles}, {21'h0, r.cyc}, "reported cycles");
    chk({2'h0, o_pc_next}, {2'h0, r.pc}, "next pc");
    if (r.op <= `CMBE_OP_FSUMUL) chk({8'h0, o_product}, {8'h0, r.res}, "product");
    if (r.op <= `CMBE_OP_FSUMUL)
      chk({16'h0, o_status}, {16'h0, r.st[7:2], r.x[1:0]}, "multiply flags");
    if (r.op >= `CMBE_OP_CMP && r.op <= `CMBE_OP_CMP_CONST)
      chk({16'h0, o_status}, {16'h0, r.res[7:0]}, "compare flags");
    if (r.op >= `CMBE_OP_REL_CALL && r.op <= `CMBE_OP_EPTR_CALL)
      chk({1'b0, o_push_we, o_ret_addr}, 24'h400101, "return push");
    if (r.op == 6'h3F) chk({o_pc_we, o_product_we, o_status_we, o_push_we}, 24'h0, "unknown op");
  endtask

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    #20000;
    fails++;
    close_out;
  end

  initial begin
    fails = 0;
    compares = 0;
    i_nrst = 1'b0;
    i_valid = 1'b0;
    {i_op, i_rd_val, i_rr_val, i_const, i_io_val, i_status, i_bit_sel, i_next_two_word} = 50'h0;
    repeat (6) @(posedge i_clk);
    chk({o_ready, o_done}, 24'h2, "reset state");
    i_nrst <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) go(rows[i]);
    $display("test table done");
    // multiply, a refused compare while busy, then a compare taken back to back
    @(posedge i_clk);
    i_valid <= 1'b1;
    {i_op, i_rd_val, i_rr_val, i_status} <= {`CMBE_OP_UMUL, 8'h03, 8'h05, 8'h00};
    @(posedge i_clk);
    i_op <= `CMBE_OP_CMP;
    @(posedge i_clk);
    #1 chk({o_done, o_product_we, o_product}, 24'h03000F, "multiply done");
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1 chk({o_done, o_status_we, 6'h0, o_status}, 24'h00C035, "back to back compare");
    @(posedge i_clk);
    #1 chk({23'h0, o_done}, 24'h0, "no extra done");
    $display("test back to back done");
    // reset in mid operation
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_op <= `CMBE_OP_EPTR_CALL;
    @(posedge i_clk);
    i_valid <= 1'b0;
    i_nrst <= 1'b0;
    #1 chk({o_ready, o_done, o_push_we}, 24'h4, "reset mid call");
    @(posedge i_clk);
    i_nrst <= 1'b1;
    go(rows[0]);
    $display("test mid reset done");
    close_out;
  end
endmodule // tb_top

// ===== rtl/cmbe_consts.vh
`ifndef CMBE_CONSTS_VH
`define CMBE_CONSTS_VH

// operation codes presented on i_op
`define CMBE_OP_W           6
`define CMBE_OP_UMUL        6'h00
`define CMBE_OP_SMUL        6'h01
`define CMBE_OP_SUMUL       6'h02
`define CMBE_OP_FUMUL       6'h03
`define CMBE_OP_FSMUL       6'h04
`define CMBE_OP_FSUMUL      6'h05
`define CMBE_OP_REL_JUMP    6'h06
`define CMBE_OP_PTR_JUMP    6'h07
`define CMBE_OP_EPTR_JUMP   6'h08
`define CMBE_OP_ABS_JUMP    6'h09
`define CMBE_OP_REL_CALL    6'h0A
`define CMBE_OP_PTR_CALL    6'h0B
`define CMBE_OP_EPTR_CALL   6'h0C
`define CMBE_OP_SKIP_EQ     6'h0D
`define CMBE_OP_CMP         6'h0E
`define CMBE_OP_CMP_BORROW  6'h0F
`define CMBE_OP_CMP_CONST   6'h10
`define CMBE_OP_SKIP_RB_CLR 6'h11
`define CMBE_OP_SKIP_RB_SET 6'h12
`define CMBE_OP_SKIP_IO_CLR 6'h13
`define CMBE_OP_SKIP_IO_SET 6'h14
`define CMBE_OP_BR_FLAG_SET 6'h15
`define CMBE_OP_BR_FLAG_CLR 6'h16
`define CMBE_OP_BR_SGE      6'h17
`define CMBE_OP_BR_SLT      6'h18
`define CMBE_OP_BR_USH      6'h19
`define CMBE_OP_BR_ULO      6'h1A
`define CMBE_OP_BR_HSET     6'h1B
`define CMBE_OP_BR_HCLR     6'h1C
`define CMBE_OP_BR_TSET     6'h1D
`define CMBE_OP_BR_TCLR     6'h1E
`define CMBE_OP_BR_VSET     6'h1F
`define CMBE_OP_BR_VCLR     6'h20
`define CMBE_OP_BR_IEN      6'h21
`define CMBE_OP_BR_IDIS     6'h22

// status register bit positions
`define CMBE_F_C 0
`define CMBE_F_Z 1
`define CMBE_F_N 2
`define CMBE_F_V 3
`define CMBE_F_S 4
`define CMBE_F_H 5
`define CMBE_F_T 6
`define CMBE_F_I 7

// program counter layout
`define CMBE_PC_W   22
`define CMBE_PC_LOW 16
`define CMBE_EXT_W  6

// cycle counts
`define CMBE_CYC_W        3
`define CMBE_CYC_ONE      3'h1
`define CMBE_CYC_MUL      3'h2
`define CMBE_CYC_JUMP     3'h2
`define CMBE_CYC_ABS_JUMP 3'h3
`define CMBE_CYC_CALL     3'h3
`define CMBE_CYC_ECALL    3'h3
`define CMBE_CYC_CMP      3'h1
`define CMBE_CYC_BR_TAKEN 3'h2

`endif

// ===== rtl/cmbe_exec.v
`timescale 1ns/1ps
`include "cmbe_consts.vh"

module cmbe_exec (
  // clock and reset
  input  wire                      i_clk,
  input  wire                      i_nrst,
  // request
  input  wire                      i_valid,
  input  wire [`CMBE_OP_W-1:0]     i_op,
  input  wire [7:0]                i_rd_val,
  input  wire [7:0]                i_rr_val,
  input  wire [7:0]                i_const,
  input  wire [2:0]                i_bit_sel,
  input  wire [7:0]                i_io_val,
  input  wire [11:0]               i_offset,
  input  wire [`CMBE_PC_W-1:0]     i_abs_target,
  input  wire                      i_next_two_word,
  // core state
  input  wire [`CMBE_PC_W-1:0]     i_pc,
  input  wire [15:0]               i_z_ptr,
  input  wire [`CMBE_EXT_W-1:0]    i_ext_addr,
  input  wire [7:0]                i_status,
  // handshake
  output wire                      o_ready,
  output reg                       o_done,
  // results
  output reg  [`CMBE_PC_W-1:0]     o_pc_next,
  output wire                      o_pc_we,
  output reg  [15:0]               o_product,
  output wire                      o_product_we,
  output reg  [7:0]                o_status,
  output wire                      o_status_we,
  output reg  [`CMBE_PC_W-1:0]     o_ret_addr,
  output wire                      o_push_we,
  output reg  [`CMBE_CYC_W-1:0]    o_cycles
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg                      state_r;
  reg                      state_nxt;
  reg [`CMBE_CYC_W-1:0]    rem_r;
  reg [`CMBE_CYC_W-1:0]    rem_nxt;
  reg                      done_nxt;
  reg                      pc_we_r;
  reg                      prod_we_r;
  reg                      stat_we_r;
  reg                      push_we_r;

  // per-request combinational results
  reg [`CMBE_PC_W-1:0]     pc_c;
  reg [15:0]               prod_c;
  reg [7:0]                stat_c;
  reg [`CMBE_CYC_W-1:0]    cyc_c;
  reg                      pc_we_c;
  reg                      prod_we_c;
  reg                      stat_we_c;
  reg                      push_we_c;
  reg                      br_cond;
  reg                      skip_cond;
  reg                      is_branch;
  reg                      is_skip;
  reg                      is_io_skip;

  wire                     accept;
  wire [`CMBE_PC_W-1:0]    pc_rel;
  wire [`CMBE_PC_W-1:0]    pc_inc1;
  wire [`CMBE_PC_W-1:0]    pc_skip;
  wire [`CMBE_CYC_W-1:0]   skip_extra;

  // multiplier operands, sign chosen per variant
  wire                     a_signed;
  wire                     b_signed;
  wire signed [8:0]        mul_a;
  wire signed [8:0]        mul_b;
  wire signed [17:0]       mul_full;
  wire [15:0]              mul_raw;
  wire                     frac;

  // compare datapath
  wire [7:0]               cmp_b;
  wire                     cmp_cin;
  wire [7:0]               cmp_res;
  wire [7:0]               bit_mask;
  wire                     cmp_c;
  wire                     cmp_h;
  wire                     cmp_v;

  // flag sources shared by several operations
  wire                     flag_sel;
  wire                     sign_lt;
  wire                     mul_c;
  wire                     mul_z;

  assign accept = i_valid && (state_r == ST_IDLE);
  assign o_ready = (state_r == ST_IDLE);

  assign a_signed = (i_op == `CMBE_OP_SMUL) || (i_op == `CMBE_OP_SUMUL) ||
                    (i_op == `CMBE_OP_FSMUL) || (i_op == `CMBE_OP_FSUMUL);
  assign b_signed = (i_op == `CMBE_OP_SMUL) || (i_op == `CMBE_OP_FSMUL);
  assign frac     = (i_op == `CMBE_OP_FUMUL) || (i_op == `CMBE_OP_FSMUL) || (i_op == `CMBE_OP_FSUMUL);
  assign mul_a    = {a_signed & i_rd_val[7], i_rd_val};
  assign mul_b    = {b_signed & i_rr_val[7], i_rr_val};
  assign mul_full = mul_a * mul_b;
  assign mul_raw  = mul_full[15:0];
  assign mul_c    = mul_raw[15];
  // fractional zero looks at the shifted result
  assign mul_z    = frac ? (mul_raw[14:0] == 15'h0000) : (mul_raw == 16'h0000);

  assign cmp_b   = (i_op == `CMBE_OP_CMP_CONST) ? i_const : i_rr_val;
  assign cmp_cin = (i_op == `CMBE_OP_CMP_BORROW) ? i_status[`CMBE_F_C] : 1'b0;
  assign cmp_res = i_rd_val - cmp_b - {7'h00, cmp_cin};
  assign bit_mask = 8'h01 << i_bit_sel;
  assign cmp_c   = (~i_rd_val[7] & cmp_b[7]) | (cmp_b[7] & cmp_res[7]) | (cmp_res[7] & ~i_rd_val[7]);
  assign cmp_h   = (~i_rd_val[3] & cmp_b[3]) | (cmp_b[3] & cmp_res[3]) | (cmp_res[3] & ~i_rd_val[3]);
  assign cmp_v   = (i_rd_val[7] & ~cmp_b[7] & ~cmp_res[7]) | (~i_rd_val[7] & cmp_b[7] & cmp_res[7]);

  assign pc_inc1    = i_pc + 22'h000001;
  assign pc_rel     = i_pc + {{10{i_offset[11]}}, i_offset} + 22'h000001;
  assign pc_skip    = i_pc + (i_next_two_word ? 22'h000003 : 22'h000002);
  assign skip_extra = i_next_two_word ? 3'h2 : 3'h1;
  assign flag_sel   = i_status[i_bit_sel];
  assign sign_lt    = i_status[`CMBE_F_N] ^ i_status[`CMBE_F_V];

  // branch condition per operation
  always @* begin
    br_cond   = 1'b0;
    is_branch = 1'b1;
    case (i_op)
      `CMBE_OP_BR_FLAG_SET: br_cond = flag_sel;
      `CMBE_OP_BR_FLAG_CLR: br_cond = ~flag_sel;
      `CMBE_OP_BR_SGE:      br_cond = ~sign_lt;
      `CMBE_OP_BR_SLT:      br_cond = sign_lt;
      `CMBE_OP_BR_USH:      br_cond = ~i_status[`CMBE_F_C];
      `CMBE_OP_BR_ULO:      br_cond = i_status[`CMBE_F_C];
      `CMBE_OP_BR_HSET:     br_cond = i_status[`CMBE_F_H];
      `CMBE_OP_BR_HCLR:     br_cond = ~i_status[`CMBE_F_H];
      `CMBE_OP_BR_TSET:     br_cond = i_status[`CMBE_F_T];
      `CMBE_OP_BR_TCLR:     br_cond = ~i_status[`CMBE_F_T];
      `CMBE_OP_BR_VSET:     br_cond = i_status[`CMBE_F_V];
      `CMBE_OP_BR_VCLR:     br_cond = ~i_status[`CMBE_F_V];
      `CMBE_OP_BR_IEN:      br_cond = i_status[`CMBE_F_I];
      `CMBE_OP_BR_IDIS:     br_cond = ~i_status[`CMBE_F_I];
      default:              is_branch = 1'b0;
    endcase
  end

  // skip condition per operation
  always @* begin
    skip_cond  = 1'b0;
    is_skip    = 1'b1;
    is_io_skip = 1'b0;
    case (i_op)
      `CMBE_OP_SKIP_EQ:     skip_cond = (i_rd_val == i_rr_val);
      `CMBE_OP_SKIP_RB_CLR: skip_cond = ((i_rr_val & bit_mask) == 8'h00);
      `CMBE_OP_SKIP_RB_SET: skip_cond = ((i_rr_val & bit_mask) != 8'h00);
      `CMBE_OP_SKIP_IO_CLR: begin
        skip_cond  = ((i_io_val & bit_mask) == 8'h00);
        is_io_skip = 1'b1;
      end
      `CMBE_OP_SKIP_IO_SET: begin
        skip_cond  = ((i_io_val & bit_mask) != 8'h00);
        is_io_skip = 1'b1;
      end
      default:              is_skip = 1'b0;
    endcase
  end

  // result per operation
  always @* begin
    pc_c      = pc_inc1;
    prod_c    = 16'h0000;
    stat_c    = i_status;
    cyc_c     = `CMBE_CYC_ONE;
    pc_we_c   = 1'b0;
    prod_we_c = 1'b0;
    stat_we_c = 1'b0;
    push_we_c = 1'b0;
    case (i_op)
      `CMBE_OP_UMUL, `CMBE_OP_SMUL, `CMBE_OP_SUMUL,
      `CMBE_OP_FUMUL, `CMBE_OP_FSMUL, `CMBE_OP_FSUMUL: begin
        prod_c = frac ? {mul_raw[14:0], 1'b0} : mul_raw;
        stat_c[`CMBE_F_C] = mul_c;
        stat_c[`CMBE_F_Z] = mul_z;
        cyc_c     = `CMBE_CYC_MUL;
        prod_we_c = 1'b1;
        stat_we_c = 1'b1;
      end
      `CMBE_OP_REL_JUMP: begin
        pc_c    = pc_rel;
        cyc_c   = `CMBE_CYC_JUMP;
        pc_we_c = 1'b1;
      end
      `CMBE_OP_PTR_JUMP: begin
        pc_c    = {{`CMBE_EXT_W{1'b0}}, i_z_ptr};
        cyc_c   = `CMBE_CYC_JUMP;
        pc_we_c = 1'b1;
      end
      `CMBE_OP_EPTR_JUMP: begin
        pc_c    = {i_ext_addr, i_z_ptr};
        cyc_c   = `CMBE_CYC_JUMP;
        pc_we_c = 1'b1;
      end
      `CMBE_OP_ABS_JUMP: begin
        pc_c    = i_abs_target;
        cyc_c   = `CMBE_CYC_ABS_JUMP;
        pc_we_c = 1'b1;
      end
      `CMBE_OP_REL_CALL: begin
        pc_c      = pc_rel;
        cyc_c     = `CMBE_CYC_CALL;
        pc_we_c   = 1'b1;
        push_we_c = 1'b1;
      end
      `CMBE_OP_PTR_CALL: begin
        pc_c      = {{`CMBE_EXT_W{1'b0}}, i_z_ptr};
        cyc_c     = `CMBE_CYC_CALL;
        pc_we_c   = 1'b1;
        push_we_c = 1'b1;
      end
      `CMBE_OP_EPTR_CALL: begin
        pc_c      = {i_ext_addr, i_z_ptr};
        cyc_c     = `CMBE_CYC_ECALL;
        pc_we_c   = 1'b1;
        push_we_c = 1'b1;
      end
      `CMBE_OP_CMP, `CMBE_OP_CMP_BORROW, `CMBE_OP_CMP_CONST: begin
        stat_c[`CMBE_F_N] = cmp_res[7];
        stat_c[`CMBE_F_C] = cmp_c;
        stat_c[`CMBE_F_H] = cmp_h;
        stat_c[`CMBE_F_V] = cmp_v;
        stat_c[`CMBE_F_S] = cmp_res[7] ^ cmp_v;
        // borrow form keeps Z only while the whole chain stays zero
        stat_c[`CMBE_F_Z] = (cmp_res == 8'h00) &
                            ((i_op != `CMBE_OP_CMP_BORROW) | i_status[`CMBE_F_Z]);
        cyc_c     = `CMBE_CYC_CMP;
        stat_we_c = 1'b1;
      end
      default: begin
        if (is_branch) begin
          pc_c    = br_cond ? pc_rel : pc_inc1;
          cyc_c   = br_cond ? `CMBE_CYC_BR_TAKEN : `CMBE_CYC_ONE;
          pc_we_c = 1'b1;
        end else if (is_skip) begin
          pc_c    = skip_cond ? pc_skip : pc_inc1;
          cyc_c   = (skip_cond ? (`CMBE_CYC_ONE + skip_extra) : `CMBE_CYC_ONE) +
                    {2'b00, is_io_skip};
          pc_we_c = 1'b1;
        end
      end
    endcase
  end

  always @* begin
    state_nxt = state_r;
    rem_nxt   = rem_r;
    done_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          if (cyc_c == `CMBE_CYC_ONE) begin
            done_nxt = 1'b1;
          end else begin
            state_nxt = ST_RUN;
            rem_nxt   = cyc_c;
          end
        end
      end
      ST_RUN: begin
        rem_nxt = rem_r - 3'h1;
        // leave one cycle early so that the done cycle is also a ready cycle
        if (rem_r == 3'h2) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        rem_nxt   = 3'h0;
      end
    endcase
  end

  // sequencer
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
      rem_r   <= 3'h0;
      o_done  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rem_r   <= rem_nxt;
      o_done  <= done_nxt;
    end
  end

  // results are taken at accept and stand until the next accept
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pc_next  <= 22'h000000;
      o_product  <= 16'h0000;
      o_status   <= 8'h00;
      o_ret_addr <= 22'h000000;
      o_cycles   <= 3'h0;
      pc_we_r    <= 1'b0;
      prod_we_r  <= 1'b0;
      stat_we_r  <= 1'b0;
      push_we_r  <= 1'b0;
    end else if (accept) begin
      o_pc_next  <= pc_c;
      o_product  <= prod_c;
      o_status   <= stat_c;
      o_ret_addr <= pc_inc1;
      o_cycles   <= cyc_c;
      pc_we_r    <= pc_we_c;
      prod_we_r  <= prod_we_c;
      stat_we_r  <= stat_we_c;
      push_we_r  <= push_we_c;
    end
  end

  assign o_pc_we      = o_done & pc_we_r;
  assign o_product_we = o_done & prod_we_r;
  assign o_status_we  = o_done & stat_we_r;
  assign o_push_we    = o_done & push_we_r;

endmodule // cmbe_exec
